// file: verilog/shp_cfg.svh
// Constants of the serial host register port: offsets, fields, reset values and times.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef SHP_CFG_SVH
`define SHP_CFG_SVH

// ---------------------------------------------------------------
// Word and command layout
// ---------------------------------------------------------------
`define SHP_WORD_BITS      16
`define SHP_LAST_BIT       5'h0f
`define SHP_CMD_RW_BIT     15
`define SHP_ADDR_MSB       5
`define SHP_RW_READ        1'b1

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SHP_OFF_PROC_DIS   6'h00
`define SHP_OFF_ERR_FLAG   6'h02
`define SHP_OFF_STD_STAT   6'h04
`define SHP_OFF_PID_FMT    6'h0a
`define SHP_OFF_RASTER     6'h0e
`define SHP_OFF_CHK_RANGE  6'h12
`define SHP_OFF_PID_LINES  6'h1b

// ---------------------------------------------------------------
// Reset values and writable bits
// ---------------------------------------------------------------
`define SHP_RST_PROC_DIS   16'h0000
`define SHP_RST_ERR_FLAG   16'h0000
`define SHP_RST_PID_FMT    16'h0000
`define SHP_RST_CHK_RANGE  16'h0000
`define SHP_RST_PID_LINES  16'h0000
`define SHP_MASK_ERR_FLAG  16'h7fff
`define SHP_MASK_FULL      16'hffff

// ---------------------------------------------------------------
// Times
// ---------------------------------------------------------------
`define SHP_CLK_KHZ        40000
`define SHP_RESET_MIN_MS   1
`define SHP_RESET_MIN_CYC  (`SHP_RESET_MIN_MS * `SHP_CLK_KHZ)
`define SHP_SCLK_MAX_KHZ   6600
`define SHP_SCLK_MIN_CYC   ((`SHP_CLK_KHZ + `SHP_SCLK_MAX_KHZ - 1) / `SHP_SCLK_MAX_KHZ)

`endif

// file: verilog/shp_pkg.sv
// Types of the serial host register port.
// Assumes nothing beyond a SystemVerilog compiler.
package shp_pkg;

    // Transfer sequencer states.
    typedef enum logic [1:0] {
        SHP_CMD,
        SHP_RD,
        SHP_WR,
        SHP_DONE
    } shp_state_t;

endpackage : shp_pkg

// file: verilog/shp_link_if.sv
// Carrier of the sampled pin events from the pin front to the core.
// Assumes both ends run on the single system clock.
`timescale 1ns/1ps
`default_nettype none

interface shp_link_if;
    logic rise;
    logic fall;
    logic data;
    logic sclk_lvl;
    logic cs_lvl;
    logic selected;
    logic test_mode;

    modport front (output rise, fall, data, sclk_lvl, cs_lvl, selected, test_mode);
    modport core  (input  rise, fall, data, sclk_lvl, cs_lvl, selected, test_mode);
endinterface : shp_link_if

`default_nettype wire

// file: verilog/shp_sync.sv
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level that changes rarely against the clock.
`timescale 1ns/1ps
`default_nettype none

module shp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_q;

    // The first stage is read only by the second stage.
    always_comb begin
        nxt_meta = d;
        nxt_q    = meta_ff;
    end

    // Register both stages.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= nxt_meta;
            q       <= nxt_q;
        end
    end
endmodule : shp_sync

`default_nettype wire

// file: verilog/shp_pin_front.sv
// Pin front: synchronises the shared port pins and finds serial clock edges.
// Assumes the serial clock is much slower than the system clock.
`timescale 1ns/1ps
`default_nettype none

module shp_pin_front (
    input  wire logic  clock,
    input  wire logic  resetn,
    input  wire logic  port_sel,
    input  wire logic  serial_clk,
    input  wire logic  chip_sel_n,
    input  wire logic  serial_in,
    shp_link_if.front  lk
);
    logic [3:0] pins_s;
    logic       sclk_prev_ff;
    logic       nxt_sclk_prev;

    // All four pins come from outside the clock domain. Chip select is inverted
    // before the flops so that a cleared synchroniser reads as deselected after reset.
    shp_sync #(.WIDTH(4)) u_sync (
        .clock  (clock),
        .resetn (resetn),
        .d      ({port_sel, serial_clk, ~chip_sel_n, serial_in}),
        .q      (pins_s)
    );

    // Delayed serial clock level for edge finding.
    always_comb begin
        nxt_sclk_prev = pins_s[2];
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclk_prev_ff <= 1'b0;
        end else begin
            sclk_prev_ff <= nxt_sclk_prev;
        end
    end

    // Edges and levels handed to the core.
    assign lk.rise      = pins_s[2] & ~sclk_prev_ff;
    assign lk.fall      = ~pins_s[2] & sclk_prev_ff;
    assign lk.data      = pins_s[0];
    assign lk.sclk_lvl  = pins_s[2];
    assign lk.cs_lvl    = ~pins_s[1];
    assign lk.test_mode = pins_s[3];
    assign lk.selected  = pins_s[1] & ~pins_s[3];
endmodule : shp_pin_front

`default_nettype wire

// file: verilog/shp_host_port.sv
// Serial host register port: command/data shifter, register file and test port routing.
// Assumes pins are asynchronous to clock and status inputs come from logic on clock.
//
// Functional notes
// - Select pin low routes shared pins to the host register port.
// - Select pin high routes pins to test port; master reset becomes test reset.
// - Serial output floats unless chip select is active or the select pin routes pins to the test port.
// - Command is sent MSB first: read/write flag, nine reserved, six address bits.
// - Flag one means read, flag zero means write.
// - Command bits are captured on serial clock rising edges.
// - Write data MSB follows command LSB; input always sampled on rising edges.
// - Read data MSB is driven after the falling edge ending the command.
// - Remaining read bits shift out on successive falling edges.
// - Every register has its own address; narrow status may share one.
// - Master reset held low restores all registers and state to defaults.
// - While reset is held low every output floats; here only the serial output floats and the test pins are driven low.
`include "shp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module shp_host_port
    import shp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        port_sel,
    input  wire logic        serial_clk,
    input  wire logic        chip_sel_n,
    input  wire logic        serial_in,
    input  wire logic        test_dout,
    input  wire logic [15:0] std_status,
    input  wire logic [15:0] raster_status,
    output var  logic        serial_out_ff,
    output var  logic        serial_out_oe_ff,
    output var  logic        test_clk_ff,
    output var  logic        test_mode_sel_ff,
    output var  logic        test_din_ff,
    output var  logic        test_reset_n_ff,
    output var  logic [15:0] proc_disable_ff,
    output var  logic [15:0] error_flag_ff,
    output var  logic [15:0] pid_format_ff,
    output var  logic [15:0] check_range_ff,
    output var  logic [15:0] pid_lines_ff
);
    shp_link_if lk ();

    shp_state_t  state_ff;
    shp_state_t  nxt_state;
    logic [4:0]  cnt_ff;
    logic [4:0]  nxt_cnt;
    logic [15:0] cmd_ff;
    logic [15:0] nxt_cmd;
    logic [15:0] shift_ff;
    logic [15:0] nxt_shift;
    logic        nxt_serial_out;
    logic        nxt_serial_out_oe;
    logic        nxt_test_clk;
    logic        nxt_test_mode_sel;
    logic        nxt_test_din;
    logic        nxt_test_reset_n;
    logic        wr_en;
    logic [5:0]  wr_addr;
    logic [15:0] wr_word;
    logic [15:0] nxt_proc_disable;
    logic [15:0] nxt_error_flag;
    logic [15:0] nxt_pid_format;
    logic [15:0] nxt_check_range;
    logic [15:0] nxt_pid_lines;

    // ---------------------------------------------------------------
    // Pin front
    // ---------------------------------------------------------------

    // Synchronised pins and serial clock edges.
    shp_pin_front u_front (
        .clock      (clock),
        .resetn     (resetn),
        .port_sel   (port_sel),
        .serial_clk (serial_clk),
        .chip_sel_n (chip_sel_n),
        .serial_in  (serial_in),
        .lk         (lk.front)
    );

    // ---------------------------------------------------------------
    // Register read decode
    // ---------------------------------------------------------------

    // Each register answers at its own offset; unmapped offsets read zero.
    function automatic logic [15:0] reg_read(input logic [5:0] addr);
        logic [15:0] val;
        val = 16'h0000;
        case (addr)
            `SHP_OFF_PROC_DIS:  val = proc_disable_ff;
            `SHP_OFF_ERR_FLAG:  val = error_flag_ff & `SHP_MASK_ERR_FLAG;
            `SHP_OFF_STD_STAT:  val = std_status;
            `SHP_OFF_PID_FMT:   val = pid_format_ff;
            `SHP_OFF_RASTER:    val = raster_status;
            `SHP_OFF_CHK_RANGE: val = check_range_ff;
            `SHP_OFF_PID_LINES: val = pid_lines_ff;
            default:            val = 16'h0000;
        endcase
        return val;
    endfunction : reg_read

    // ---------------------------------------------------------------
    // Transfer sequencer
    // ---------------------------------------------------------------

    // Write target is the captured address; the write word is the shifted data with the last data bit appended.
    assign wr_addr = cmd_ff[`SHP_ADDR_MSB:0];
    assign wr_word = {shift_ff[14:0], lk.data};

    // Next state of the shifter, the serial output and the test pin routing.
    always_comb begin
        nxt_state         = state_ff;
        nxt_cnt           = cnt_ff;
        nxt_cmd           = cmd_ff;
        nxt_shift         = shift_ff;
        nxt_serial_out    = serial_out_ff;
        wr_en             = 1'b0;
        if (!lk.selected) begin
            nxt_state      = SHP_CMD;
            nxt_cnt        = 5'h00;
            nxt_serial_out = 1'b0;
        end else begin
            case (state_ff)
                SHP_CMD: begin
                    if (lk.rise) begin
                        nxt_cmd = {cmd_ff[14:0], lk.data};
                        nxt_cnt = cnt_ff + 5'h01;
                        if (cnt_ff == `SHP_LAST_BIT) begin
                            nxt_cnt = 5'h00;
                            if (nxt_cmd[`SHP_CMD_RW_BIT] == `SHP_RW_READ) begin
                                nxt_state = SHP_RD;
                                nxt_shift = reg_read(nxt_cmd[`SHP_ADDR_MSB:0]);
                            end else begin
                                nxt_state = SHP_WR;
                            end
                        end
                    end
                end
                SHP_RD: begin
                    if (lk.fall) begin
                        nxt_serial_out = shift_ff[15];
                        nxt_shift      = {shift_ff[14:0], 1'b0};
                        nxt_cnt        = cnt_ff + 5'h01;
                        if (cnt_ff == `SHP_LAST_BIT) begin
                            nxt_state = SHP_DONE;
                        end
                    end
                end
                SHP_WR: begin
                    if (lk.rise) begin
                        nxt_shift = wr_word;
                        nxt_cnt   = cnt_ff + 5'h01;
                        if (cnt_ff == `SHP_LAST_BIT) begin
                            wr_en     = 1'b1;
                            nxt_state = SHP_DONE;
                        end
                    end
                end
                SHP_DONE: begin
                    nxt_state = SHP_DONE;
                end
                default: begin
                    nxt_state = SHP_CMD;
                end
            endcase
        end
        if (lk.test_mode) begin
            nxt_serial_out = test_dout;
        end
        nxt_serial_out_oe = lk.test_mode | lk.selected;
        nxt_test_clk      = lk.test_mode & lk.sclk_lvl;
        nxt_test_mode_sel = lk.test_mode & lk.cs_lvl;
        nxt_test_din      = lk.test_mode & lk.data;
        nxt_test_reset_n  = lk.test_mode;
    end

    // Register the sequencer; reset floats the serial output and drives the test pins low.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff         <= SHP_CMD;
            cnt_ff           <= 5'h00;
            cmd_ff           <= 16'h0000;
            shift_ff         <= 16'h0000;
            serial_out_ff    <= 1'b0;
            serial_out_oe_ff <= 1'b0;
            test_clk_ff      <= 1'b0;
            test_mode_sel_ff <= 1'b0;
            test_din_ff      <= 1'b0;
            test_reset_n_ff  <= 1'b0;
        end else begin
            state_ff         <= nxt_state;
            cnt_ff           <= nxt_cnt;
            cmd_ff           <= nxt_cmd;
            shift_ff         <= nxt_shift;
            serial_out_ff    <= nxt_serial_out;
            serial_out_oe_ff <= nxt_serial_out_oe;
            test_clk_ff      <= nxt_test_clk;
            test_mode_sel_ff <= nxt_test_mode_sel;
            test_din_ff      <= nxt_test_din;
            test_reset_n_ff  <= nxt_test_reset_n;
        end
    end

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------

    // Writable registers take a completed write word; status offsets ignore writes.
    always_comb begin
        nxt_proc_disable = proc_disable_ff;
        nxt_error_flag   = error_flag_ff;
        nxt_pid_format   = pid_format_ff;
        nxt_check_range  = check_range_ff;
        nxt_pid_lines    = pid_lines_ff;
        if (wr_en) begin
            case (wr_addr)
                `SHP_OFF_PROC_DIS:  nxt_proc_disable = wr_word & `SHP_MASK_FULL;
                `SHP_OFF_ERR_FLAG:  nxt_error_flag   = wr_word & `SHP_MASK_ERR_FLAG;
                `SHP_OFF_PID_FMT:   nxt_pid_format   = wr_word & `SHP_MASK_FULL;
                `SHP_OFF_CHK_RANGE: nxt_check_range  = wr_word & `SHP_MASK_FULL;
                `SHP_OFF_PID_LINES: nxt_pid_lines    = wr_word & `SHP_MASK_FULL;
                default:            nxt_proc_disable = proc_disable_ff;
            endcase
        end
    end

    // Register the configuration words.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            proc_disable_ff <= `SHP_RST_PROC_DIS;
            error_flag_ff   <= `SHP_RST_ERR_FLAG;
            pid_format_ff   <= `SHP_RST_PID_FMT;
            check_range_ff  <= `SHP_RST_CHK_RANGE;
            pid_lines_ff    <= `SHP_RST_PID_LINES;
        end else begin
            proc_disable_ff <= nxt_proc_disable;
            error_flag_ff   <= nxt_error_flag;
            pid_format_ff   <= nxt_pid_format;
            check_range_ff  <= nxt_check_range;
            pid_lines_ff    <= nxt_pid_lines;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------

    // Output driver floats one cycle after deselection outside test mode.
    a_oe_needs_select: assert property (@(posedge clock) disable iff (!resetn)
        (!lk.selected && !lk.test_mode) |=> !serial_out_oe_ff)
        else $error("serial output driven while not selected");

    // Host mode drives the output while selected and holds test pins idle.
    a_host_routing: assert property (@(posedge clock) disable iff (!resetn)
        (lk.selected && !lk.test_mode) |=> serial_out_oe_ff && !test_clk_ff && !test_reset_n_ff)
        else $error("host mode routing wrong");

    // Test mode follows the serial clock pin onto the test clock.
    a_test_routing: assert property (@(posedge clock) disable iff (!resetn)
        lk.test_mode |=> test_clk_ff == $past(lk.sclk_lvl) && test_reset_n_ff && serial_out_oe_ff)
        else $error("test mode routing wrong");

    // Deselection in host mode returns to a fresh command with a cleared counter.
    a_deselect_abort: assert property (@(posedge clock) disable iff (!resetn)
        (!lk.selected && !lk.test_mode) |=> state_ff == SHP_CMD && cnt_ff == 5'h00
        && !serial_out_ff)
        else $error("deselect did not abort transfer");

    // Sixteenth command bit with the flag set starts a read of the addressed word.
    a_read_select: assert property (@(posedge clock) disable iff (!resetn)
        (lk.selected && state_ff == SHP_CMD && lk.rise && cnt_ff == `SHP_LAST_BIT && cmd_ff[14])
        |=> state_ff == SHP_RD && shift_ff == $past(reg_read({cmd_ff[4:0], lk.data})))
        else $error("read not started with addressed word");

    // Sixteenth command bit with the flag clear starts a write.
    a_write_select: assert property (@(posedge clock) disable iff (!resetn)
        (lk.selected && state_ff == SHP_CMD && lk.rise && cnt_ff == `SHP_LAST_BIT && !cmd_ff[14])
        |=> state_ff == SHP_WR && cnt_ff == 5'h00)
        else $error("write not started after sixteen bits");

    // While a selected read runs, the output changes only on falling serial clock edges.
    a_read_stable: assert property (@(posedge clock) disable iff (!resetn)
        (lk.selected && !lk.test_mode && state_ff == SHP_RD && !lk.fall) |=> $stable(serial_out_ff))
        else $error("read bit changed without falling edge");

    // A finished write to the control word lands the shifted data.
    a_write_lands: assert property (@(posedge clock) disable iff (!resetn)
        (lk.selected && state_ff == SHP_WR && lk.rise && cnt_ff == `SHP_LAST_BIT
         && cmd_ff[5:0] == `SHP_OFF_PROC_DIS)
        |=> proc_disable_ff == $past({shift_ff[14:0], lk.data}) ##1 state_ff == SHP_DONE || !lk.selected)
        else $error("write data not stored");

    // Held reset keeps the serial output driver off, test reset low and the control word at its reset value.
    a_reset_float: assert property (@(posedge clock)
        !resetn |-> !serial_out_oe_ff && !test_reset_n_ff && proc_disable_ff == `SHP_RST_PROC_DIS)
        else $error("outputs active during reset");

    // Main scenarios.
    c_read_done:  cover property (@(posedge clock) disable iff (!resetn)
        state_ff == SHP_RD ##1 state_ff == SHP_DONE);
    c_write_done: cover property (@(posedge clock) disable iff (!resetn) wr_en);
    c_abort_cmd:  cover property (@(posedge clock) disable iff (!resetn)
        state_ff == SHP_CMD && cnt_ff > 5'h03 && !lk.selected);
    c_test_mode:  cover property (@(posedge clock) disable iff (!resetn) $rose(test_clk_ff));
endmodule : shp_host_port

`default_nettype wire

// file: test/shp_host_model.sv
// Host model: drives serial clock bursts, chip select and serial input.
// Assumes the bench clock runs at 40 MHz; the serial clock period is 200 ns.
`timescale 1ns/1ps
`default_nettype none

module shp_host_model (
    input  wire logic clock,
    input  wire logic sdo_line,
    output var  logic serial_clk,
    output var  logic chip_sel_n,
    output var  logic serial_in
);
    // Idle: clock stands low between frames, device not selected.
    initial begin
        serial_clk = 1'b0;
        chip_sel_n = 1'b1;
        serial_in  = 1'b0;
    end

    // One serial clock phase of 100 ns, changes land just after an edge.
    task automatic half();
        repeat (4) @(posedge clock);
        #1;
    endtask : half

    // One access: command then data, MSB first; nbits < 32 aborts early.
    task automatic xfer(input logic [15:0] cmd, input logic [15:0] wdata,
                        input int nbits, output logic [15:0] rdata);
        logic [31:0] frame;
        frame = {cmd, wdata};
        rdata = 16'h0000;
        @(posedge clock);
        #1;
        chip_sel_n = 1'b0;
        half();
        for (int i = 0; i < nbits; i++) begin
            serial_clk = 1'b0;
            serial_in  = frame[31-i];
            half();
            serial_clk = 1'b1;
            if (i >= 16) begin
                rdata[31-i] = sdo_line;
            end
            half();
        end
        serial_clk = 1'b0;
        half();
        chip_sel_n = 1'b1;
        serial_in  = ~serial_in;
        half();
        half();
    endtask : xfer

    // Sets the three shared pins as static levels.
    task automatic pins(input logic c, input logic s, input logic d);
        @(posedge clock);
        #1;
        serial_clk = c;
        chip_sel_n = s;
        serial_in  = d;
    endtask : pins
endmodule : shp_host_model

`default_nettype wire

// file: test/shp_host_port_tb.sv
// Testbench of the serial host register port.
// Assumes the host model drives the pins and status inputs change only between transfers.
`include "shp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module shp_host_port_tb;
    logic        clock;
    logic        resetn;
    logic        port_sel;
    logic        test_dout;
    logic [15:0] std_status;
    logic [15:0] raster_status;
    wire  logic  serial_clk;
    wire  logic  chip_sel_n;
    wire  logic  serial_in;
    wire  logic  sdo_line;
    logic        so;
    logic        oe;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        trst_n;
    logic [15:0] regs [5];
    logic [15:0] ex [5];
    logic [5:0]  offs [5] = '{`SHP_OFF_PROC_DIS, `SHP_OFF_ERR_FLAG, `SHP_OFF_PID_FMT,
                              `SHP_OFF_CHK_RANGE, `SHP_OFF_PID_LINES};
    int          fails;
    int          n_checks;

    // Released output line floats unless enabled.
    assign sdo_line = oe ? so : 1'bz;

    shp_host_model host (.clock(clock), .sdo_line(sdo_line), .serial_clk(serial_clk),
                         .chip_sel_n(chip_sel_n), .serial_in(serial_in));

    shp_host_port DUT (.clock(clock), .resetn(resetn), .port_sel(port_sel),
        .serial_clk(serial_clk), .chip_sel_n(chip_sel_n), .serial_in(serial_in),
        .test_dout(test_dout), .std_status(std_status), .raster_status(raster_status),
        .serial_out_ff(so), .serial_out_oe_ff(oe), .test_clk_ff(tck),
        .test_mode_sel_ff(tms), .test_din_ff(tdi), .test_reset_n_ff(trst_n),
        .proc_disable_ff(regs[0]), .error_flag_ff(regs[1]), .pid_format_ff(regs[2]),
        .check_range_ff(regs[3]), .pid_lines_ff(regs[4]));

    // System clock of 25 ns.
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // Register write through the serial port.
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] r;
        host.xfer({1'b0, 9'h000, a}, d, 32, r);
    endtask : wr

    // Register read with a given command word, compared with exp.
    task automatic rdc(input logic [15:0] cmd, input logic [15:0] exp);
        logic [15:0] r;
        host.xfer(cmd, 16'h0000, 32, r);
        `CHK(r, exp)
    endtask : rdc

    // Compares every writable register with its expected value.
    task automatic regs_chk();
        for (int i = 0; i < 5; i++) `CHK(regs[i], ex[i])
    endtask : regs_chk

    // Bounded run length.
    initial begin
        repeat (100000) @(posedge clock);
        fails++;
        final_report();
    end

    // Main sequence.
    initial begin
        logic [15:0] r;
        fails = 0;
        n_checks = 0;
        resetn = 1'b0;
        port_sel = 1'b0;
        test_dout = 1'b0;
        std_status = 16'h1234;
        raster_status = 16'hbeef;
        for (int i = 0; i < 5; i++) ex[i] = 16'h0000;
        repeat (3) @(posedge clock);
        #1;
        `CHK({oe, trst_n}, 2'b00)
        resetn = 1'b1;
        @(posedge clock);
        #1;
        `CHK(oe, 1'b0)
        repeat (5) @(posedge clock);
        #1;
        `CHK(oe, 1'b0)
        for (int i = 0; i < 5; i++) rdc({1'b1, 9'h000, offs[i]}, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            r = 16'hc3a5 ^ 16'(i * 257);
            ex[i] = (i == 1) ? (r & `SHP_MASK_ERR_FLAG) : r;
            wr(offs[i], r);
        end
        regs_chk();
        for (int i = 0; i < 5; i++) rdc({1'b1, 9'h000, offs[i]}, ex[i]);
        rdc({1'b1, 9'h1ff, offs[3]}, ex[3]);
        rdc({1'b1, 9'h000, `SHP_OFF_STD_STAT}, 16'h1234);
        raster_status = 16'h0f1e;
        rdc({1'b1, 9'h000, `SHP_OFF_RASTER}, 16'h0f1e);
        wr(`SHP_OFF_STD_STAT, 16'hffff);
        wr(6'h3f, 16'hffff);
        regs_chk();
        rdc({1'b1, 9'h000, 6'h3f}, 16'h0000);
        host.xfer({1'b0, 9'h000, offs[0]}, 16'h0000, 24, r);
        host.xfer({1'b1, 9'h000, offs[1]}, 16'h0000, 7, r);
        regs_chk();
        `CHK(oe, 1'b0)
        rdc({1'b1, 9'h000, offs[0]}, ex[0]);
        port_sel = 1'b1;
        test_dout = 1'b1;
        host.pins(1'b1, 1'b0, 1'b1);
        repeat (4) @(posedge clock);
        #1;
        `CHK({oe, so, trst_n, tck, tms, tdi}, 6'b111101)
        host.pins(1'b0, 1'b1, 1'b0);
        repeat (4) @(posedge clock);
        #1;
        `CHK({tck, tms, tdi}, 3'b010)
        wr(offs[0], 16'h0f0f);
        regs_chk();
        port_sel = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        `CHK({oe, trst_n, tck, tms}, 4'b0000)
        rdc({1'b1, 9'h000, offs[2]}, ex[2]);
        resetn = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        `CHK({oe, so, trst_n, regs[0], regs[4]}, 35'h0)
        resetn = 1'b1;
        @(posedge clock);
        #1;
        `CHK(oe, 1'b0)
        repeat (5) @(posedge clock);
        #1;
        for (int i = 0; i < 5; i++) ex[i] = 16'h0000;
        regs_chk();
        final_report();
    end
endmodule : shp_host_port_tb

`default_nettype wire
